/* File: lcafe_pkg.sv */
// Purpose: Shared constants and types of the LPDDR2 command/access front end
// Assumes: One system clock; pins already split into rise and fall halves
// Notes: Command codes and field positions are fixed here only
package lcafe_pkg;
	localparam int CA_W = 10;
	localparam int BANK_W = 3;
	localparam int ROW_W = 14;
	localparam int COL_W = 11;
	localparam int BANKS = 8;
	localparam int WL_W = 3;
	// Command code positions in the rising half of the command/address bus
	localparam logic [1:0] CODE_ACT = 2'h2;
	localparam logic [2:0] CODE_WR = 3'h1;
	localparam logic [2:0] CODE_RD = 3'h5;
	localparam logic [3:0] CODE_PRE = 4'hb;
	// Address field positions
	localparam int BANK_LSB = 7;
	localparam int ROW_HI_LSB = 2;
	localparam int ROW_HI_W = 5;
	localparam int ROW_LO_W = 9;
	localparam int COL_LO_LSB = 3;
	localparam int COL_LO_W = 2;
	// Column mask of the x32 organisation (10 column bits)
	localparam logic [COL_W-1:0] COL_MASK_X32 = 11'h3ff;
	localparam logic [COL_W-1:0] COL_MASK_X16 = 11'h7ff;
	// Burst length selection codes
	localparam logic [1:0] BL_4 = 2'h1;
	localparam logic [1:0] BL_8 = 2'h2;
	localparam logic [1:0] BL_16 = 2'h3;
	// Reset values
	localparam logic [ROW_W-1:0] RST_ROW = 14'h0000;
	localparam logic [BANKS-1:0] RST_BANK_OPEN = 8'h00;
	localparam logic [1:0] RST_BL = 2'h1;
	typedef enum logic [2:0] {
		CMD_NOP = 3'b000,
		CMD_ACT = 3'b001,
		CMD_RD = 3'b010,
		CMD_WR = 3'b011,
		CMD_PRE = 3'b100
	} lcafe_cmd_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WR_WAIT = 2'b01,
		ST_WR_DATA = 2'b10,
		ST_RD = 2'b11
	} lcafe_state_t;
endpackage

/* File: lcafe_buf2.sv */
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Same clock on both sides
// Notes: Input ready is registered from the next fill count, no comb path
`timescale 1ns/100ps
module lcafe_buf2 #(
	parameter int W = 64
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	input wire logic [W-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	output logic [W-1:0] out_data_out,
	input wire logic out_ready_in
);
	logic [W-1:0] mem [2];
	logic [W-1:0] next_mem [2];
	logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [1:0] count, next_count;
	logic push, pop;

	assign out_valid_out = (count != 2'h0);
	assign out_data_out = mem[rd_ptr];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_ready_in && out_valid_out;

	always_comb begin
		next_mem = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (push) begin
			next_mem[wr_ptr] = in_data_in;
			next_wr_ptr = ~wr_ptr;
		end
		if (pop) begin
			next_rd_ptr = ~rd_ptr;
		end
		if (push && !pop) begin
			next_count = count + 2'h1;
		end else if (pop && !push) begin
			next_count = count - 2'h1;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			mem[0] <= '0;
			mem[1] <= '0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
			in_ready_out <= 1'b1;
		end else begin
			mem <= next_mem;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			in_ready_out <= (next_count != 2'h2);
		end
	end
endmodule

/* File: lcafe_front_end.sv */
// Purpose: Command capture, bank/row tracking and burst sequencing
// Assumes: Pin halves arrive per clock as rise and fall words
// Notes: Mode fields (burst length, order, write latency) are plain inputs
// Summary of operation
// - Every command, address and bank field comes from the 10-bit bus.
// - A command takes one clock, with a rising half and a falling half.
// - One core word of four beats moves as two beats on each clock.
// - Accesses are bursts from the start column in the chosen order.
// - An activate opens the addressed row in the addressed bank.
// - A read or write takes its bank and start column from its address.
// - Rows are 14 bits, banks 3, columns 11 on x16 and 10 on x32.
// - Chip select and clock enable are taken once per clock, rising.
// - A write byte whose mask bit is high is not written.
// - Each mask bit and strobe serves one eight-bit lane from lane zero.
// - Read strobes are edge aligned with the data they carry.
`timescale 1ns/100ps
module lcafe_front_end
	import lcafe_pkg::*;
#(
	parameter int DQ_W = 32,
	parameter int LANES = DQ_W / 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic cke_in,
	input wire logic cs_n_in,
	input wire logic [lcafe_pkg::CA_W-1:0] ca_rise_in,
	input wire logic [lcafe_pkg::CA_W-1:0] ca_fall_in,
	input wire logic [1:0] burst_len_in,
	input wire logic burst_interleave_in,
	input wire logic [lcafe_pkg::WL_W-1:0] write_latency_in,
	input wire logic [DQ_W-1:0] dq_rise_in,
	input wire logic [DQ_W-1:0] dq_fall_in,
	input wire logic [LANES-1:0] dm_rise_in,
	input wire logic [LANES-1:0] dm_fall_in,
	output logic core_req_valid_out,
	output logic core_req_write_out,
	output logic [lcafe_pkg::BANK_W-1:0] core_bank_out,
	output logic [lcafe_pkg::ROW_W-1:0] core_row_out,
	output logic [lcafe_pkg::COL_W-1:0] core_col_out,
	output logic [4*DQ_W-1:0] core_wdata_out,
	output logic [4*LANES-1:0] core_wkeep_out,
	input wire logic core_rdata_valid_in,
	input wire logic [4*DQ_W-1:0] core_rdata_in,
	output logic core_rdata_ready_out,
	output logic [DQ_W-1:0] dq_rise_out,
	output logic [DQ_W-1:0] dq_fall_out,
	output logic dq_oe_out,
	output logic [LANES-1:0] dqs_rise_out,
	output logic [LANES-1:0] dqs_fall_out,
	output logic dqs_oe_out,
	output logic [lcafe_pkg::BANKS-1:0] bank_open_out,
	output logic cmd_error_out
);
	import lcafe_pkg::*;
	localparam int SW = 2 + 2 * CA_W + 2 * DQ_W + 2 * LANES;
	localparam logic [COL_W-1:0] COL_MASK = (DQ_W == 32) ?
		COL_MASK_X32 : COL_MASK_X16;

	function automatic logic [2:0] burst_words(input logic [1:0] bl);
		unique case (bl)
			BL_16: burst_words = 3'h4;
			BL_8: burst_words = 3'h2;
			default: burst_words = 3'h1;
		endcase
	endfunction

	// Column of core word idx; the wrap stays inside the burst block
	function automatic logic [COL_W-1:0] burst_col(
		input logic [COL_W-1:0] base, input logic [1:0] idx,
		input logic [1:0] bl, input logic ilv);
		logic [3:0] step, sum, msk;
		step = {idx, 2'b00};
		sum = ilv ? (base[3:0] ^ step) : (base[3:0] + step);
		unique case (bl)
			BL_16: msk = 4'hf;
			BL_8: msk = 4'h7;
			default: msk = 4'h3;
		endcase
		burst_col = {base[COL_W-1:4], (base[3:0] & ~msk) | (sum & msk)};
		burst_col = burst_col & COL_MASK;
	endfunction

	function automatic lcafe_cmd_t decode_cmd(input logic [CA_W-1:0] r);
		if (r[1:0] == CODE_ACT) decode_cmd = CMD_ACT;
		else if (r[2:0] == CODE_WR) decode_cmd = CMD_WR;
		else if (r[2:0] == CODE_RD) decode_cmd = CMD_RD;
		else if (r[3:0] == CODE_PRE) decode_cmd = CMD_PRE;
		else decode_cmd = CMD_NOP;
	endfunction

	// Two-stage synchroniser for every pin input
	logic [SW-1:0] sync1, sync2;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {cke_in, cs_n_in, ca_rise_in, ca_fall_in,
				dq_rise_in, dq_fall_in, dm_rise_in, dm_fall_in};
			sync2 <= sync1;
		end
	end

	logic cke_s, cs_n_s;
	logic [CA_W-1:0] ca_r_s, ca_f_s;
	logic [DQ_W-1:0] dq_r_s, dq_f_s;
	logic [LANES-1:0] dm_r_s, dm_f_s;
	assign {cke_s, cs_n_s, ca_r_s, ca_f_s, dq_r_s, dq_f_s, dm_r_s, dm_f_s}
		= sync2;

	lcafe_cmd_t cmd;
	logic cmd_valid;
	logic [BANK_W-1:0] s_bank;
	logic [ROW_W-1:0] s_row;
	logic [COL_W-1:0] s_col;
	assign cmd_valid = cke_s && !cs_n_s;
	assign cmd = decode_cmd(ca_r_s);
	assign s_bank = ca_r_s[BANK_LSB +: BANK_W];
	assign s_row = {ca_r_s[ROW_HI_LSB +: ROW_HI_W], ca_f_s[ROW_LO_W-1:0]};
	assign s_col = {ca_f_s[COL_W-COL_LO_W-1:0],
		ca_r_s[COL_LO_LSB +: COL_LO_W]} & COL_MASK;

	lcafe_state_t state, next_state;
	logic [ROW_W-1:0] open_row [BANKS];
	logic [ROW_W-1:0] next_open_row [BANKS];
	logic [BANKS-1:0] next_bank_open;
	logic [BANK_W-1:0] cur_bank, next_bank;
	logic [COL_W-1:0] col_base, next_col;
	logic [1:0] bl_sel, next_bl;
	logic ilv, next_ilv, wr_half, next_half;
	logic [2:0] word_idx, next_idx;
	logic [WL_W-1:0] wl_cnt, next_wl;
	logic [2*DQ_W-1:0] lo_data, next_lo_data;
	logic [2*LANES-1:0] lo_keep, next_lo_keep;
	logic next_req_v, next_req_w, next_err;
	logic [BANK_W-1:0] next_req_bank;
	logic [ROW_W-1:0] next_req_row;
	logic [COL_W-1:0] next_req_col;
	logic [4*DQ_W-1:0] next_wdata;
	logic [4*LANES-1:0] next_keep;

	always_comb begin
		next_state = state;
		next_open_row = open_row;
		next_bank_open = bank_open_out;
		next_bank = cur_bank;
		next_col = col_base;
		next_bl = bl_sel;
		next_ilv = ilv;
		next_half = wr_half;
		next_idx = word_idx;
		next_wl = wl_cnt;
		next_lo_data = lo_data;
		next_lo_keep = lo_keep;
		next_req_v = 1'b0;
		next_req_w = core_req_write_out;
		next_req_bank = core_bank_out;
		next_req_row = core_row_out;
		next_req_col = core_col_out;
		next_wdata = core_wdata_out;
		next_keep = core_wkeep_out;
		next_err = 1'b0;
		// Commands during a burst are refused, never queued
		if (state != ST_IDLE && cmd_valid && cmd != CMD_NOP) begin
			next_err = 1'b1;
		end
		unique case (state)
			ST_IDLE: begin
				if (cmd_valid) begin
					unique case (cmd)
						CMD_NOP: begin
						end
						CMD_ACT: begin
							next_open_row[s_bank] = s_row;
							next_bank_open[s_bank] = 1'b1;
						end
						CMD_PRE: begin
							next_bank_open[s_bank] = 1'b0;
						end
						CMD_RD, CMD_WR: begin
							if (!bank_open_out[s_bank]) begin
								next_err = 1'b1;
							end else begin
								next_bank = s_bank;
								next_col = s_col;
								next_bl = burst_len_in;
								next_ilv = burst_interleave_in;
								next_idx = 3'h0;
								next_half = 1'b0;
								next_wl = write_latency_in;
								if (cmd == CMD_RD) begin
									next_state = ST_RD;
								end else if (write_latency_in == '0) begin
									next_state = ST_WR_DATA;
								end else begin
									next_state = ST_WR_WAIT;
								end
							end
						end
					endcase
				end
			end
			ST_WR_WAIT: begin
				next_wl = wl_cnt - 1'b1;
				if (wl_cnt == 1) begin
					next_state = ST_WR_DATA;
				end
			end
			ST_WR_DATA: begin
				if (!wr_half) begin
					next_lo_data = {dq_f_s, dq_r_s};
					next_lo_keep = ~{dm_f_s, dm_r_s};
					next_half = 1'b1;
				end else begin
					next_req_v = 1'b1;
					next_req_w = 1'b1;
					next_req_bank = cur_bank;
					next_req_row = open_row[cur_bank];
					next_req_col = burst_col(col_base, word_idx[1:0],
						bl_sel, ilv);
					next_wdata = {dq_f_s, dq_r_s, lo_data};
					next_keep = {~dm_f_s, ~dm_r_s, lo_keep};
					next_half = 1'b0;
					next_idx = word_idx + 3'h1;
					if (next_idx == burst_words(bl_sel)) begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_RD: begin
				next_req_v = 1'b1;
				next_req_w = 1'b0;
				next_req_bank = cur_bank;
				next_req_row = open_row[cur_bank];
				next_req_col = burst_col(col_base, word_idx[1:0],
					bl_sel, ilv);
				next_idx = word_idx + 3'h1;
				if (next_idx == burst_words(bl_sel)) begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
			for (int i = 0; i < BANKS; i++) begin
				open_row[i] <= RST_ROW;
			end
			bank_open_out <= RST_BANK_OPEN;
			cur_bank <= '0;
			col_base <= '0;
			bl_sel <= RST_BL;
			ilv <= 1'b0;
			wr_half <= 1'b0;
			word_idx <= 3'h0;
			wl_cnt <= '0;
			lo_data <= '0;
			lo_keep <= '0;
			core_req_valid_out <= 1'b0;
			core_req_write_out <= 1'b0;
			core_bank_out <= '0;
			core_row_out <= RST_ROW;
			core_col_out <= '0;
			core_wdata_out <= '0;
			core_wkeep_out <= '0;
			cmd_error_out <= 1'b0;
		end else begin
			state <= next_state;
			open_row <= next_open_row;
			bank_open_out <= next_bank_open;
			cur_bank <= next_bank;
			col_base <= next_col;
			bl_sel <= next_bl;
			ilv <= next_ilv;
			wr_half <= next_half;
			word_idx <= next_idx;
			wl_cnt <= next_wl;
			lo_data <= next_lo_data;
			lo_keep <= next_lo_keep;
			core_req_valid_out <= next_req_v;
			core_req_write_out <= next_req_w;
			core_bank_out <= next_req_bank;
			core_row_out <= next_req_row;
			core_col_out <= next_req_col;
			core_wdata_out <= next_wdata;
			core_wkeep_out <= next_keep;
			cmd_error_out <= next_err;
		end
	end

	// Read return: buffered so the serialiser can lag the core
	logic buf_valid, pop, ser_half, next_ser_half;
	logic [4*DQ_W-1:0] buf_data;
	logic [2*DQ_W-1:0] hold, next_hold;
	logic [DQ_W-1:0] next_dq_r, next_dq_f;
	logic next_oe;

	lcafe_buf2 #(.W(4*DQ_W)) u_rbuf (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.in_valid_in(core_rdata_valid_in),
		.in_data_in(core_rdata_in),
		.in_ready_out(core_rdata_ready_out),
		.out_valid_out(buf_valid),
		.out_data_out(buf_data),
		.out_ready_in(pop)
	);

	assign pop = buf_valid && !ser_half;

	always_comb begin
		next_ser_half = 1'b0;
		next_hold = hold;
		next_dq_r = dq_rise_out;
		next_dq_f = dq_fall_out;
		next_oe = 1'b0;
		if (ser_half) begin
			next_dq_r = hold[DQ_W-1:0];
			next_dq_f = hold[2*DQ_W-1:DQ_W];
			next_oe = 1'b1;
		end else if (pop) begin
			next_dq_r = buf_data[DQ_W-1:0];
			next_dq_f = buf_data[2*DQ_W-1:DQ_W];
			next_hold = buf_data[4*DQ_W-1:2*DQ_W];
			next_ser_half = 1'b1;
			next_oe = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ser_half <= 1'b0;
			hold <= '0;
			dq_rise_out <= '0;
			dq_fall_out <= '0;
			dq_oe_out <= 1'b0;
			dqs_rise_out <= '0;
			dqs_fall_out <= '0;
			dqs_oe_out <= 1'b0;
		end else begin
			ser_half <= next_ser_half;
			hold <= next_hold;
			dq_rise_out <= next_dq_r;
			dq_fall_out <= next_dq_f;
			dq_oe_out <= next_oe;
			// Strobe high in the rise half: edge aligned per lane
			dqs_rise_out <= {LANES{next_oe}};
			dqs_fall_out <= '0;
			dqs_oe_out <= next_oe;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	sequence s_rd_ok;
		state == ST_IDLE && cmd_valid && cmd == CMD_RD
			&& bank_open_out[s_bank];
	endsequence
	sequence s_rd_bl4;
		s_rd_ok ##0 burst_len_in == BL_4;
	endsequence

	property p_act_open;
		state == ST_IDLE && cmd_valid && cmd == CMD_ACT |=>
			bank_open_out[$past(s_bank)]
			&& open_row[$past(s_bank)] == $past(s_row);
	endproperty
	a_act_open: assert property (p_act_open)
		else $error("activate did not open row");
	property p_closed_err;
		state == ST_IDLE && cmd_valid && cmd == CMD_RD
			&& !bank_open_out[s_bank] |=> cmd_error_out ##1
			!core_req_valid_out;
	endproperty
	a_closed_err: assert property (p_closed_err)
		else $error("read to closed bank not refused");
	property p_rd_target;
		s_rd_ok |-> ##2 core_req_valid_out && !core_req_write_out
			&& core_bank_out == $past(s_bank, 2);
	endproperty
	a_rd_target: assert property (p_rd_target)
		else $error("read request has wrong bank");
	property p_req_row;
		core_req_valid_out |-> core_row_out == open_row[core_bank_out];
	endproperty
	a_req_row: assert property (p_req_row)
		else $error("request row differs from open row");
	property p_bl4_one;
		s_rd_bl4 |-> ##2 core_req_valid_out ##1 !core_req_valid_out;
	endproperty
	a_bl4_one: assert property (p_bl4_one)
		else $error("burst of four gave wrong request count");
	property p_cke_low;
		state == ST_IDLE && !cke_s |=> state == ST_IDLE
			&& $stable(bank_open_out);
	endproperty
	a_cke_low: assert property (p_cke_low)
		else $error("command taken with clock enable low");
	property p_ser_two;
		pop |=> dq_oe_out && dqs_rise_out == {LANES{1'b1}} ##1 dq_oe_out
			&& {dq_fall_out, dq_rise_out} == $past(hold);
	endproperty
	a_ser_two: assert property (p_ser_two)
		else $error("read word not sent over two clocks");
	property p_wr_mask;
		next_req_v && next_req_w |=>
			core_wkeep_out[4*LANES-1:3*LANES] == ~$past(dm_f_s)
			&& core_wkeep_out[3*LANES-1:2*LANES] == ~$past(dm_r_s);
	endproperty
	a_wr_mask: assert property (p_wr_mask)
		else $error("write keep mask does not follow mask pins");
	property p_col_range;
		core_req_valid_out |-> (core_col_out & ~COL_MASK) == '0;
	endproperty
	a_col_range: assert property (p_col_range)
		else $error("column uses an unused address bit");
endmodule

/* File: lcafe_ctrl_model.sv */
// Purpose: Controller model driving command and write data pins
// Assumes: One slot per clock, pins change on the falling edge
// Notes: Released lines toggle so a stale value never looks valid
`timescale 1ns/100ps
module lcafe_ctrl_model (
	input wire logic clk_sys_in,
	output logic cke_out,
	output logic cs_n_out,
	output logic [lcafe_pkg::CA_W-1:0] ca_rise_out,
	output logic [lcafe_pkg::CA_W-1:0] ca_fall_out,
	output logic [31:0] dq_rise_out,
	output logic [31:0] dq_fall_out,
	output logic [3:0] dm_rise_out,
	output logic [3:0] dm_fall_out
);
	import lcafe_pkg::*;
	typedef struct {
		logic cke;
		logic sel;
		logic dv;
		logic [19:0] ca;
		logic [71:0] d;
	} lcafe_slot_t;
	lcafe_slot_t q[$];
	lcafe_slot_t s;
	task automatic put(input logic cke, input logic sel, input logic dv,
		input logic [19:0] ca, input logic [71:0] d);
		lcafe_slot_t t;
		t.cke = cke;
		t.sel = sel;
		t.dv = dv;
		t.ca = ca;
		t.d = d;
		q.push_back(t);
	endtask
	initial begin
		cke_out = 1'b1;
		cs_n_out = 1'b1;
		{ca_rise_out, ca_fall_out} = '0;
		{dq_rise_out, dq_fall_out, dm_rise_out, dm_fall_out} = '0;
		s.cke = 1'b1;
	end
	always @(negedge clk_sys_in) begin
		if (q.size() > 0) begin
			s = q.pop_front();
		end else begin
			s.cke = 1'b1;
			s.sel = 1'b0;
			s.dv = 1'b0;
		end
		// Single-rate pins settle half a clock before the rising edge
		cke_out <= s.cke;
		cs_n_out <= !s.sel;
		// Both halves of one command held for one whole clock
		ca_rise_out <= s.sel ? s.ca[19:10] : ~ca_rise_out;
		ca_fall_out <= s.sel ? s.ca[9:0] : ~ca_fall_out;
		// One mask bit for each eight-bit lane, lane zero lowest
		dq_rise_out <= s.dv ? s.d[71:40] : ~dq_rise_out;
		dq_fall_out <= s.dv ? s.d[39:8] : ~dq_fall_out;
		dm_rise_out <= s.dv ? s.d[7:4] : ~dm_rise_out;
		dm_fall_out <= s.dv ? s.d[3:0] : ~dm_fall_out;
	end
endmodule

/* File: test_lpddr2_cmd_access_front_end.sv */
// Purpose: Self-checking bench of the command/access front end
// Assumes: x32 organisation, core answers every read word at once
// Notes: Commands are spaced until idle except the eight opening activates and the refusal cases
`timescale 1ns/100ps
module test_lpddr2_cmd_access_front_end;
	import lcafe_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic cke_in, cs_n_in;
	logic [CA_W-1:0] ca_rise_in, ca_fall_in;
	logic [1:0] burst_len_in = 2'h1;
	logic burst_interleave_in = 1'b0;
	logic [WL_W-1:0] write_latency_in = 3'h1;
	logic [31:0] dq_rise_in, dq_fall_in, dq_rise_out, dq_fall_out;
	logic [3:0] dm_rise_in, dm_fall_in, dqs_rise_out, dqs_fall_out;
	logic core_req_valid_out, core_req_write_out, core_rdata_ready_out;
	logic [BANK_W-1:0] core_bank_out;
	logic [ROW_W-1:0] core_row_out;
	logic [COL_W-1:0] core_col_out;
	logic [127:0] core_wdata_out, w;
	logic [15:0] core_wkeep_out;
	logic core_rdata_valid_in = 1'b0;
	logic [127:0] core_rdata_in = '0;
	logic dq_oe_out, dqs_oe_out, cmd_error_out, took, saw_full = 1'b0;
	logic [7:0] bank_open_out, open_exp = '0;
	logic [13:0] rows [8];
	logic [172:0] e, g;
	logic [172:0] exp_req[$];
	logic [63:0] exp_dq[$];
	logic [127:0] rq[$];
	int mismatches = 0, tests_run = 0, seed = 33, err_seen = 0, err_exp = 0;
	lcafe_ctrl_model u_ctrl (.clk_sys_in, .cke_out(cke_in), .cs_n_out(cs_n_in),
		.ca_rise_out(ca_rise_in), .ca_fall_out(ca_fall_in),
		.dq_rise_out(dq_rise_in), .dq_fall_out(dq_fall_in),
		.dm_rise_out(dm_rise_in), .dm_fall_out(dm_fall_in));
	lcafe_front_end #(.DQ_W(32)) DUT (.clk_sys_in, .rst_in, .cke_in, .cs_n_in,
		.ca_rise_in, .ca_fall_in, .burst_len_in, .burst_interleave_in,
		.write_latency_in, .dq_rise_in, .dq_fall_in, .dm_rise_in, .dm_fall_in,
		.core_req_valid_out, .core_req_write_out, .core_bank_out,
		.core_row_out, .core_col_out, .core_wdata_out, .core_wkeep_out,
		.core_rdata_valid_in, .core_rdata_in, .core_rdata_ready_out,
		.dq_rise_out, .dq_fall_out, .dq_oe_out, .dqs_rise_out, .dqs_fall_out,
		.dqs_oe_out, .bank_open_out, .cmd_error_out);
	always #5 clk_sys_in = ~clk_sys_in;
	task automatic check(input logic [172:0] got, input logic [172:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while ((u_ctrl.q.size() + exp_req.size() + rq.size() + exp_dq.size()) > 0
			&& n < 400) begin
			@(negedge clk_sys_in);
			n++;
		end
		if (n >= 400) begin
			mismatches++;
			print_verdict();
		end else begin
			repeat (4) @(negedge clk_sys_in);
			check(173'(bank_open_out), 173'(open_exp));
			check(173'(err_seen), 173'(err_exp));
		end
	endtask
	// ok low models a command that lands while a burst is still running
	task automatic act(input logic [2:0] b, input logic cke, input logic ok);
		logic [31:0] x;
		x = $random(seed);
		u_ctrl.put(cke, 1'b1, 1'b0, {b, x[13:9], 2'b10, x[20], x[8:0]}, '0);
		if (cke && ok) begin
			open_exp[b] = 1'b1;
			rows[b] = x[13:0];
		end
		if (cke && !ok) err_exp++;
	endtask
	task automatic pre(input logic [2:0] b);
		logic [31:0] x;
		x = $random(seed);
		u_ctrl.put(1'b1, 1'b1, 1'b0, {b, x[2:0], 4'hb, x[12:3]}, '0);
		open_exp[b] = 1'b0;
	endtask
	task automatic rw(input logic wr, input logic [2:0] b, input logic [1:0] blc,
		input logic ilv, input logic [2:0] wl);
		logic [31:0] x;
		logic [10:0] base, c, m;
		logic [15:0] k;
		int nw;
		x = $random(seed);
		base = x[10:0];
		nw = (blc == 2'h3) ? 4 : (blc == 2'h2) ? 2 : 1;
		m = 11'(4 * nw - 1);
		burst_len_in = blc;
		burst_interleave_in = ilv;
		write_latency_in = wl;
		u_ctrl.put(1'b1, 1'b1, 1'b0, {b, x[12:11], base[1:0], wr ? 3'h1 : 3'h5,
			x[13], base[10:2]}, '0);
		if (!open_exp[b]) err_exp++;
		else if (wr) repeat (wl) u_ctrl.put(1'b1, 1'b0, 1'b0, '0, '0);
		for (int i = 0; i < nw && open_exp[b]; i++) begin
			c = ilv ? base ^ 11'(4 * i) : (base & ~m) | ((base + 11'(4 * i)) & m);
			c = c & COL_MASK_X32;
			w = {$random(seed), $random(seed), $random(seed), $random(seed)};
			k = 16'($random(seed));
			if (wr) begin
				u_ctrl.put(1'b1, 1'b0, 1'b1, '0, {w[31:0], w[63:32], k[3:0], k[7:4]});
				u_ctrl.put(1'b1, 1'b0, 1'b1, '0, {w[95:64], w[127:96], k[11:8],
					k[15:12]});
			end
			exp_req.push_back({wr, b, rows[b], c, wr ? w : 128'h0, wr ? ~k : 16'h0});
		end
	endtask
	always @(posedge clk_sys_in)
		took = core_rdata_valid_in && core_rdata_ready_out;
	// Sampled on the falling edge so every registered output has settled
	always @(negedge clk_sys_in) begin
		if (cmd_error_out === 1'b1) err_seen++;
		if (core_req_valid_out === 1'b1) begin
			e = (exp_req.size() > 0) ? exp_req.pop_front() : '1;
			g = {core_req_write_out, core_bank_out, core_row_out, core_col_out,
				core_wdata_out, core_wkeep_out};
			if (core_req_write_out !== 1'b1) g[143:0] = '0;
			check(g, e);
			if (core_req_write_out === 1'b0)
				rq.push_back({$random(seed), $random(seed), $random(seed), $random(seed)});
		end
		if (dq_oe_out === 1'b1) begin
			e = (exp_dq.size() > 0) ? {exp_dq.pop_front(), 9'h1e1} : '1;
			g = 173'({dq_rise_out, dq_fall_out, dqs_rise_out, dqs_fall_out,
				dqs_oe_out});
			check(g, e);
		end
		if (took === 1'b1) begin
			w = rq.pop_front();
			exp_dq.push_back({w[31:0], w[63:32]});
			exp_dq.push_back({w[95:64], w[127:96]});
		end
		if (core_rdata_valid_in && core_rdata_ready_out === 1'b0) saw_full = 1'b1;
		core_rdata_valid_in <= rq.size() > 0;
		core_rdata_in <= (rq.size() > 0) ? rq[0] : ~core_rdata_in;
	end
	initial begin
		repeat (16) @(negedge clk_sys_in);
		g = 173'({core_rdata_ready_out, bank_open_out, dq_oe_out,
			cmd_error_out});
		check(g, 173'({1'b1, 10'h0}));
		rst_in = 1'b0;
		for (int b = 0; b < 8; b++) act(3'(b), 1'b1, 1'b1);
		wait_idle();
		pre(3'h5);
		wait_idle();
		rw(1'b0, 3'h5, 2'h2, 1'b0, 3'h1);
		act(3'h5, 1'b0, 1'b1);
		wait_idle();
		// Every burst length code, both orders, reads and writes
		for (int i = 0; i < 16; i++) begin
			rw(i[0], 3'(i % 5), 2'(i >> 2), i[1], 3'((i >> 1) % 4 + 1));
			wait_idle();
		end
		// A command arriving inside a running burst is refused
		rw(1'b0, 3'h2, 2'h3, 1'b0, 3'h1);
		act(3'h5, 1'b1, 1'b0);
		wait_idle();
		act(3'h5, 1'b1, 1'b1);
		wait_idle();
		repeat (6) rq.push_back({$random(seed), $random(seed), $random(seed),
			$random(seed)});
		wait_idle();
		check(173'(saw_full), 173'(1'b1));
		check(173'(dq_oe_out), 173'(1'b0));
		print_verdict();
	end
endmodule
